// ---- rtl/pdr_pkg.sv ----
// constants and types for the power data report block
// assumes dword-wide configuration accesses into the power management block
package pdr_pkg;

   // dword that holds the control/status word and the power data byte
   localparam logic [7:0] PDR_CSR_OFFSET   = 8'h04;
   // byte offset of the power data register inside the block
   localparam logic [7:0] PDR_VALUE_OFFSET = 8'h07;

   // field positions inside that dword
   localparam int PDR_SEL_LSB   = 9;
   localparam int PDR_SEL_W     = 4;
   localparam int PDR_SCALE_LSB = 13;
   localparam int PDR_SCALE_W   = 2;
   localparam int PDR_VALUE_LSB = 24;
   localparam int PDR_VALUE_W   = 8;
   localparam int PDR_SEL_LANE  = 1;

   // reset values
   localparam logic [3:0] PDR_SEL_RST   = 4'h0;
   localparam logic [7:0] PDR_VALUE_RST = 8'h00;

   // selector codes
   localparam logic [3:0] PDR_SEL_D0_CONS  = 4'h0;
   localparam logic [3:0] PDR_SEL_D3_DISS  = 4'h7;
   localparam logic [3:0] PDR_SEL_COMMON   = 4'h8;
   localparam int         PDR_ENTRIES      = 9;

   // scale codes: multiply the value by this to get watts
   typedef enum logic [1:0]
   {
      PDR_SCALE_UNKNOWN = 2'h0,
      PDR_SCALE_TENTH   = 2'h1,
      PDR_SCALE_HUNDRED = 2'h2,
      PDR_SCALE_THOUS   = 2'h3
   } pdr_scale_t;

   // one table entry: scale code and worst-case power value
   typedef struct packed
   {
      pdr_scale_t scale;
      logic [7:0] value;
   } pdr_entry_t;

   // configuration request from the host side
   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pdr_cfg_req_t;

   // table load port from an eprom loader or strap logic
   typedef struct packed
   {
      logic       wr;
      logic [3:0] addr;
      pdr_entry_t data;
   } pdr_load_t;

   // default characterisation table, entries 0..8
   localparam pdr_entry_t PDR_TABLE_RST [PDR_ENTRIES] = '{
      '{PDR_SCALE_TENTH,   8'h0f},
      '{PDR_SCALE_TENTH,   8'h0a},
      '{PDR_SCALE_TENTH,   8'h05},
      '{PDR_SCALE_HUNDRED, 8'h0c},
      '{PDR_SCALE_TENTH,   8'h0e},
      '{PDR_SCALE_TENTH,   8'h09},
      '{PDR_SCALE_TENTH,   8'h04},
      '{PDR_SCALE_HUNDRED, 8'h0b},
      '{PDR_SCALE_TENTH,   8'h03}
   };

endpackage : pdr_pkg

// ---- rtl/pdr_table.sv ----
// characterisation table: scale and power value per selector code
// assumes the reader presents the next selector so data tracks it
`timescale 1ns/1ns
module pdr_table
#(
   parameter int ENTRIES = pdr_pkg::PDR_ENTRIES
)
(
   input  wire logic               mclk,
   input  wire logic               rstn,
   input  wire pdr_pkg::pdr_load_t load,
   input  wire logic [3:0]         rd_addr,
   output pdr_pkg::pdr_entry_t     rd_data
);
   import pdr_pkg::*;

   pdr_entry_t mem [ENTRIES];

   // one register per entry, reset to the table, overwritable by the loader
   for (genvar i = 0; i < ENTRIES; i++)
   begin : g_entry
      always_ff @(posedge mclk)
      begin
         if (!rstn)
            mem[i] <= PDR_TABLE_RST[i];
         else if (load.wr && load.addr == 4'(i))
            mem[i] <= load.data;
      end
   end

   // registered read; out-of-range addresses read as zero
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         rd_data <= '0;
      else if (int'(rd_addr) < ENTRIES)
         rd_data <= mem[rd_addr];
      else
         rd_data <= '0;
   end

endmodule : pdr_table

// ---- rtl/pdr_report.sv ----
// power data report: selector, scale code and power value registers
// assumes single-cycle read/write strobes from the configuration decoder;
// other control/status bits are owned elsewhere and read as zero here
//
// What this block does
// - eight-bit read-only value, zero until selected
// - implement selector and scale with value
// - unimplemented: value, selector, scale read zero
// - value follows selector, scaled by scale code
// - codes 0-7: consumed then dissipated, D0-D3
// - scale codes: unknown, tenth, hundredth, thousandth
// - function 0 multi-function: code 8 common
// - other codes reserved, value and scale zero
// - values give worst-case power per state
// - table loadable from eprom or straps
// - each function reports its own power
`timescale 1ns/1ns
module pdr_report
#(
   parameter bit IMPLEMENTED = 1'b1,
   parameter bit MULTI_FUNC  = 1'b0,
   parameter bit FUNC_ZERO   = 1'b1
)
(
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   input  wire pdr_pkg::pdr_cfg_req_t cfg_req,
   input  wire pdr_pkg::pdr_load_t    table_load,
   output logic [31:0]                cfg_rdata,
   output logic                       cfg_rvalid,
   output logic [3:0]                 data_select
);
   import pdr_pkg::*;

   localparam bit HAS_COMMON = MULTI_FUNC && FUNC_ZERO;

   logic       sel_write;
   logic [3:0] next_select;
   logic       selected;
   logic       code_valid;
   logic       next_code_valid;
   pdr_entry_t entry;
   pdr_scale_t scale_out;
   logic [7:0] value_out;
   logic [31:0] next_rdata;
   logic       hit;

   // address decode for the shared dword
   assign hit       = cfg_req.addr[7:2] == PDR_CSR_OFFSET[7:2];
   assign sel_write = cfg_req.wr && hit && cfg_req.be[PDR_SEL_LANE] && IMPLEMENTED;

   // next selector value, taken straight from the write data
   always_comb
   begin
      next_select = data_select;
      if (sel_write)
         next_select = cfg_req.wdata[PDR_SEL_LSB +: PDR_SEL_W];
   end

   // selector register
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         data_select <= PDR_SEL_RST;
      else
         data_select <= next_select;
   end

   // value reads zero until a selector write has happened
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         selected <= 1'b0;
      else if (sel_write)
         selected <= 1'b1;
   end

   // which codes this function defines
   always_comb
   begin
      next_code_valid = 1'b0;
      if (next_select <= PDR_SEL_D3_DISS)
         next_code_valid = 1'b1;
      else if (next_select == PDR_SEL_COMMON)
         next_code_valid = HAS_COMMON;
   end

   // validity kept in step with the registered table output
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         code_valid <= 1'b0;
      else
         code_valid <= next_code_valid;
   end

   // per-function table, fed the next selector so no lag appears
   pdr_table
   #(
      .ENTRIES (PDR_ENTRIES)
   )
   u_table
   (
      .mclk    (mclk),
      .rstn    (rstn),
      .load    (table_load),
      .rd_addr (next_select),
      .rd_data (entry)
   );

   // reported scale and value, zero when reserved or absent
   always_comb
   begin
      scale_out = PDR_SCALE_UNKNOWN;
      value_out = PDR_VALUE_RST;
      if (IMPLEMENTED && code_valid)
      begin
         scale_out = entry.scale;
         if (selected)
            value_out = entry.value;
      end
   end

   // read data assembly; writes to the value byte have no effect
   always_comb
   begin
      next_rdata = '0;
      if (hit && IMPLEMENTED)
      begin
         next_rdata[PDR_SEL_LSB +: PDR_SEL_W]     = data_select;
         next_rdata[PDR_SCALE_LSB +: PDR_SCALE_W] = scale_out;
         next_rdata[PDR_VALUE_LSB +: PDR_VALUE_W] = value_out;
      end
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         cfg_rdata  <= '0;
         cfg_rvalid <= 1'b0;
      end
      else
      begin
         cfg_rvalid <= cfg_req.rd;
         if (cfg_req.rd)
            cfg_rdata <= next_rdata;
      end
   end

endmodule : pdr_report

// ---- testbench/pdr_report_monitor.sv ----
// checker on the power data report ports
// assumes a bind onto every pdr_report instance
`timescale 1ns/1ns
module pdr_report_monitor
#(
   parameter bit IMPLEMENTED = 1'b1
)
(
   input wire logic                  mclk,
   input wire logic                  rstn,
   input wire pdr_pkg::pdr_cfg_req_t cfg_req,
   input wire pdr_pkg::pdr_load_t    table_load,
   input wire logic [31:0]           cfg_rdata,
   input wire logic                  cfg_rvalid,
   input wire logic [3:0]            data_select
);
   import pdr_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // selector write and control dword read
   sequence sel_wr; cfg_req.wr && cfg_req.addr[7:2] == 6'h01 && cfg_req.be[1]; endsequence
   sequence csr_rd; cfg_req.rd && cfg_req.addr[7:2] == 6'h01; endsequence
   a_read_answer: assert property (cfg_req.rd |=> cfg_rvalid)
      else $error("no answer");
   a_no_spurious: assert property (!cfg_req.rd |=> !cfg_rvalid)
      else $error("stray valid");
   a_sel_update: assert property (sel_wr |=> data_select == (IMPLEMENTED ? $past(cfg_req.wdata[12:9]) : 4'h0))
      else $error("select lost");
   a_absent_zero: assert property (!IMPLEMENTED && cfg_rvalid |-> cfg_rdata == 32'h0 && data_select == 4'h0)
      else $error("absent nonzero");
   a_sel_hold: assert property (!cfg_req.wr |=> $stable(data_select))
      else $error("select moved");
   a_read_sel: assert property (csr_rd |=> cfg_rdata[12:9] == $past(data_select))
      else $error("select readback");
   a_rsvd_zero: assert property (csr_rd ##0 data_select > 4'h8 |=> cfg_rdata[31:13] == 19'h0)
      else $error("reserved nonzero");
   a_other_zero: assert property (cfg_req.rd && cfg_req.addr[7:2] != 6'h01 |=> cfg_rdata == 32'h0)
      else $error("other dword");
   a_spare_zero: assert property (cfg_rvalid |-> cfg_rdata[23:15] == 9'h0 && cfg_rdata[8:0] == 9'h0)
      else $error("spare bits");
endmodule : pdr_report_monitor

// ---- testbench/pdr_host.sv ----
// host model issuing configuration accesses
// assumes one access at a time
`timescale 1ns/1ns
module pdr_host
(
   input  wire logic             mclk,
   input  wire logic [31:0]      rdata,
   input  wire logic             rvalid,
   output pdr_pkg::pdr_cfg_req_t req
);
   import pdr_pkg::*;
   initial req = '0;
   // write strobe for one edge
   task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge mclk);
      req <= '{1'b1, 1'b0, a, be, d};
      @(posedge mclk);
      req <= '0;
   endtask : cfg_wr
   // read, answer one cycle later
   task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d, output logic v);
      @(posedge mclk);
      req <= '{1'b0, 1'b1, a, 4'hf, 32'h0};
      @(posedge mclk);
      req <= '0;
      @(negedge mclk);
      d = rdata;
      v = rvalid;
   endtask : cfg_rd
   // select, then read
   task automatic measure(input logic [3:0] s, output logic [31:0] d, output logic v);
      cfg_wr(8'h04, 4'h2, {19'h0, s, 9'h0});
      cfg_rd(8'h04, d, v);
   endtask : measure
endmodule : pdr_host

// ---- testbench/pdr_report_tb_top.sv ----
// top testbench for the power data report
// assumes pdr_host drives the configuration side
`timescale 1ns/1ns
module pdr_report_tb_top;
   import pdr_pkg::*;
   localparam pdr_entry_t NONE = '0;
   logic         mclk;
   logic         rstn;
   logic         rvalid;
   logic         v;
   logic [31:0]  rdata;
   logic [31:0]  rdata2;
   logic [31:0]  rdata3;
   logic [31:0]  rdata4;
   logic [31:0]  d;
   pdr_cfg_req_t req;
   pdr_load_t    load;
   int           err_count = 0;
   int           n_tests = 0;
   int           cyc = 0;
   pdr_host pdr_host_inst (.mclk(mclk), .rdata(rdata), .rvalid(rvalid), .req(req));
   pdr_report pdr_report_inst (.mclk(mclk), .rstn(rstn), .cfg_req(req), .table_load(load),
      .cfg_rdata(rdata), .cfg_rvalid(rvalid), .data_select());
   pdr_report #(.MULTI_FUNC(1'b1)) pdr_report_inst2 (.mclk(mclk), .rstn(rstn), .cfg_req(req),
      .table_load(load), .cfg_rdata(rdata2), .cfg_rvalid(), .data_select());
   pdr_report #(.IMPLEMENTED(1'b0)) pdr_report_inst3 (.mclk(mclk), .rstn(rstn), .cfg_req(req),
      .table_load(load), .cfg_rdata(rdata3), .cfg_rvalid(), .data_select());
   pdr_report #(.MULTI_FUNC(1'b1), .FUNC_ZERO(1'b0)) pdr_report_inst4 (.mclk(mclk), .rstn(rstn), .cfg_req(req),
      .table_load(load), .cfg_rdata(rdata4), .cfg_rvalid(), .data_select());
   // clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // hang ceiling
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_count++;
         print_verdict();
      end
   end
   function automatic logic [31:0] word(input logic [3:0] s, input pdr_entry_t e);
      return {e.value, 9'h0, e.scale, s, 9'h0};
   endfunction : word
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   // test sequence
   initial
   begin
      rstn <= 1'b0;
      load <= '0;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      pdr_host_inst.cfg_rd(8'h04, d, v);
      check("reset", word(4'h0, '{PDR_TABLE_RST[0].scale, 8'h00}), d);
      check("rvalid", 32'h1, {31'h0, v});
      $display("reset done");
      for (int s = 0; s < 16; s++)
      begin
         pdr_host_inst.measure(s[3:0], d, v);
         check("single", word(s[3:0], s < 8 ? PDR_TABLE_RST[s] : NONE), d);
         check("func0", word(s[3:0], s < 9 ? PDR_TABLE_RST[s] : NONE), rdata2);
         check("func1", word(s[3:0], s < 8 ? PDR_TABLE_RST[s] : NONE), rdata4);
         check("absent", 32'h0, rdata3);
      end
      $display("codes done");
      pdr_host_inst.measure(4'h2, d, v);
      pdr_host_inst.cfg_wr(8'h04, 4'h8, 32'hffff_ffff);
      pdr_host_inst.cfg_wr(8'h04, 4'h1, 32'hffff_ffff);
      pdr_host_inst.cfg_rd(8'h04, d, v);
      check("ro", word(4'h2, PDR_TABLE_RST[2]), d);
      pdr_host_inst.cfg_rd(8'h00, d, v);
      check("dw0", 32'h0, d);
      $display("writes done");
      @(posedge mclk);
      load <= '{1'b1, 4'h5, '{PDR_SCALE_THOUS, 8'h5a}};
      @(posedge mclk);
      load <= '0;
      pdr_host_inst.measure(4'h5, d, v);
      check("load", word(4'h5, '{PDR_SCALE_THOUS, 8'h5a}), d);
      $display("load done");
      // mid-run reset: value back to zero, loaded entry back to default
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      pdr_host_inst.cfg_rd(8'h04, d, v);
      check("rereset", word(4'h0, '{PDR_TABLE_RST[0].scale, 8'h00}), d);
      pdr_host_inst.measure(4'h5, d, v);
      check("restore", word(4'h5, PDR_TABLE_RST[5]), d);
      $display("rereset done");
      print_verdict();
   end
endmodule : pdr_report_tb_top
bind pdr_report pdr_report_monitor #(.IMPLEMENTED(IMPLEMENTED)) pdr_report_monitor_inst (.mclk(mclk), .rstn(rstn),
   .cfg_req(cfg_req),
   .table_load(table_load), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .data_select(data_select));
